// ### logic/aux_control_bits.sv
// Auxiliary control bit bank of the microcontroller core.
// Assumes a same-clock register port; pins and the slow clock are async.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "aux_control_params.svh"
module aux_control_bits #(
  parameter int unsigned FPW_CYC1 =
    (`FPW_TIME1_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned FPW_CYC2 =
    (`FPW_TIME2_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned FPW_CYC3 =
    (`FPW_TIME3_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned SLOW_DIV = `SLOW_DIVIDE
) (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire aux_control_pkg::reg_req_t bus_req_i, // Register request
  output logic [7:0] rdata_o, // Read data, cycle after read
  input wire logic conv_done_i, // Conversion finished pulse
  input wire logic flashprog_active_i, // Flash programming busy
  input wire logic [7:0] flash_cfg_word_i, // Loaded flash config byte
  input wire logic timer_two_counter_mode_i, // Timer two counts events
  input wire logic timer_one_counter_mode_i, // Timer one counts events
  input wire logic timer_two_pin_i, // Timer two count pin
  input wire logic timer_one_pin_i, // Timer one count pin
  input wire logic slow_clock_i, // Slow clock, async
  output aux_control_pkg::arith_mode_t arith_mode_o, // Multiply/divide mode
  output logic wdog_clear_o, // Watchdog clear pulse
  output logic timer_three_clear_o, // Timer three clear pulse
  output logic conv_start_o, // Conversion requested
  output logic lowv_reset_en_o, // Low-voltage reset enabled
  output logic timer_two_count_o, // Timer two count pulse
  output logic timer_one_count_o, // Timer one count pulse
  output logic pointer_bank_sel_o, // Active data pointer
  output aux_control_pkg::flash_cfg_t flash_cfg_o, // Decoded config word
  output logic fpw_running_o, // Flash watchdog counting
  output logic irq_o // Interrupt, active high level
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic aux_control_pkg::reg_sel_t decode(input logic [15:0] addr);
    case (addr)
      `OFS_AUX_CONTROL_ONE: decode = aux_control_pkg::SEL_AUX_CONTROL_ONE;
      `OFS_ARITH_IAP_CONTROL: decode = aux_control_pkg::SEL_ARITH;
      `OFS_EVENT_STATUS: decode = aux_control_pkg::SEL_STATUS;
      `OFS_EVENT_MASK: decode = aux_control_pkg::SEL_MASK;
      `OFS_FLASH_CONFIG_HIGH: decode = aux_control_pkg::SEL_CFG;
      default: decode = aux_control_pkg::SEL_NONE;
    endcase
  endfunction

  aux_control_pkg::reg_sel_t wsel;
  aux_control_pkg::reg_sel_t rsel;
  logic [7:0] wd;

  assign wsel = bus_req_i.wr ? decode(bus_req_i.addr) : aux_control_pkg::SEL_NONE;
  assign rsel = bus_req_i.rd ? decode(bus_req_i.addr) : aux_control_pkg::SEL_NONE;
  assign wd = bus_req_i.wdata;

  // --------------------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------------------
  logic wdog_clear;
  logic timer_three_clear;
  logic conv_start;
  logic lowv_reset_disable;
  logic timer_two_input_sel;
  logic timer_one_input_sel;
  logic pointer_bank_sel;
  logic long_divide_sel;
  logic [1:0] flashprog_wdog_sel;
  logic wide_arith_sel;
  logic aux_control_one_wr;
  logic arith_wr;

  assign aux_control_one_wr = (wsel == aux_control_pkg::SEL_AUX_CONTROL_ONE);
  assign arith_wr = (wsel == aux_control_pkg::SEL_ARITH);

  // Strobes live one cycle; a write of 0 is harmless
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wdog_clear <= 1'b0;
      timer_three_clear <= 1'b0;
    end
    else
    begin
      wdog_clear <= aux_control_one_wr && wd[`AUX_CONTROL_ONE_WDOG_CLR];
      timer_three_clear <= aux_control_one_wr && wd[`AUX_CONTROL_ONE_TMR3_CLR];
    end
  end

  // Software set beats the end-of-conversion clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      conv_start <= 1'(`RST_AUX_CONTROL_ONE >> `AUX_CONTROL_ONE_CONV_START);
    else if (aux_control_one_wr)
      conv_start <= wd[`AUX_CONTROL_ONE_CONV_START];
    else if (conv_done_i)
      conv_start <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lowv_reset_disable <= 1'b0;
      timer_two_input_sel <= 1'b0;
      timer_one_input_sel <= 1'b0;
      pointer_bank_sel <= 1'b0;
    end
    else if (aux_control_one_wr)
    begin
      lowv_reset_disable <= wd[`AUX_CONTROL_ONE_LOWV_DIS];
      timer_two_input_sel <= wd[`AUX_CONTROL_ONE_T2_SEL];
      timer_one_input_sel <= wd[`AUX_CONTROL_ONE_T1_SEL];
      pointer_bank_sel <= wd[`AUX_CONTROL_ONE_PTR_SEL];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      long_divide_sel <= 1'b0;
      flashprog_wdog_sel <= 2'b00;
      wide_arith_sel <= 1'b0;
    end
    else if (arith_wr)
    begin
      long_divide_sel <= wd[`ARITH_LONG_DIV];
      flashprog_wdog_sel <= wd[`ARITH_FPW_HI:`ARITH_FPW_LO];
      wide_arith_sel <= wd[`ARITH_WIDE];
    end
  end

  assign wdog_clear_o = wdog_clear;
  assign timer_three_clear_o = timer_three_clear;
  assign conv_start_o = conv_start;
  assign lowv_reset_en_o = !lowv_reset_disable;
  assign pointer_bank_sel_o = pointer_bank_sel;

  // --------------------------------------------------------------------------
  // Arithmetic mode
  // --------------------------------------------------------------------------
  always_comb
  begin
    arith_mode_o.mul_wide = wide_arith_sel;
    if (!wide_arith_sel)
      arith_mode_o.div_mode = aux_control_pkg::DIV_8_8;
    else if (long_divide_sel)
      arith_mode_o.div_mode = aux_control_pkg::DIV_32_16;
    else
      arith_mode_o.div_mode = aux_control_pkg::DIV_16_16;
  end

  // --------------------------------------------------------------------------
  // Flash configuration word
  // --------------------------------------------------------------------------
  logic [7:0] flash_config_high;

  // Copied every cycle once out of reset; the loader owns its value
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flash_config_high <= `RST_FLASH_CONFIG_HIGH;
    else
      flash_config_high <= flash_cfg_word_i;
  end

  assign flash_cfg_o.code_protect = flash_config_high[`CFG_PROTECT];
  assign flash_cfg_o.ext_reset_pin_en = flash_config_high[`CFG_XRST_EN];
  assign flash_cfg_o.lowv_threshold_code =
    flash_config_high[`CFG_LVR_HI:`CFG_LVR_LO];

  // --------------------------------------------------------------------------
  // Counter input synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic [2:0] sync_last;
  logic [2:0] async_in;
  logic [2:0] rise;

  assign async_in = {slow_clock_i, timer_one_pin_i, timer_two_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          sync_meta[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          sync_last[gi] <= 1'b0;
        end
        else
        begin
          sync_meta[gi] <= async_in[gi];
          sync_q[gi] <= sync_meta[gi];
          sync_last[gi] <= sync_q[gi];
        end
      end
      assign rise[gi] = sync_q[gi] && !sync_last[gi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Slow clock divide by sixteen
  // --------------------------------------------------------------------------
  logic [$clog2(SLOW_DIV)-1:0] slow_count;
  logic slow_tick;

  // Slow clock must stay below half the system rate to be counted
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      slow_count <= '0;
      slow_tick <= 1'b0;
    end
    else
    begin
      slow_tick <= 1'b0;
      if (rise[2])
      begin
        if (slow_count == ($clog2(SLOW_DIV))'(SLOW_DIV - 1))
        begin
          slow_count <= '0;
          slow_tick <= 1'b1;
        end
        else
          slow_count <= slow_count + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counter event selection
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer_two_count_o <= 1'b0;
      timer_one_count_o <= 1'b0;
    end
    else
    begin
      timer_two_count_o <= timer_two_counter_mode_i &&
        (timer_two_input_sel ? slow_tick : rise[0]);
      timer_one_count_o <= timer_one_counter_mode_i &&
        (timer_one_input_sel ? slow_tick : rise[1]);
    end
  end

  // --------------------------------------------------------------------------
  // Flash-programming watchdog
  // --------------------------------------------------------------------------
  logic fpw_timeout;

  flashprog_wdog #(
    .CYC1(FPW_CYC1),
    .CYC2(FPW_CYC2),
    .CYC3(FPW_CYC3),
    .CW(20)
  ) u_fpw (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sel_i(flashprog_wdog_sel),
    .active_i(flashprog_active_i),
    .clear_i(wdog_clear),
    .timeout_o(fpw_timeout),
    .running_o(fpw_running_o)
  );

  // --------------------------------------------------------------------------
  // Event status and interrupt
  // --------------------------------------------------------------------------
  logic [7:0] event_status;
  logic [7:0] event_mask;
  logic [7:0] event_set;

  always_comb
  begin
    event_set = 8'h00;
    event_set[`EVT_FPW_TIMEOUT] = fpw_timeout;
    event_set[`EVT_CONV_DONE] = conv_done_i;
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      event_status <= `RST_EVENT;
    else if (wsel == aux_control_pkg::SEL_STATUS)
      event_status <= (event_status & ~wd) | event_set;
    else
      event_status <= event_status | event_set;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      event_mask <= `RST_EVENT;
    else if (wsel == aux_control_pkg::SEL_MASK)
      event_mask <= wd & 8'h03;
  end

  assign irq_o = |(event_status & event_mask);

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [7:0] aux_control_one_view;
  logic [7:0] arith_view;

  // Bit 5 of the first register and the upper nibble of the second read 0
  always_comb
  begin
    aux_control_one_view = 8'h00;
    aux_control_one_view[`AUX_CONTROL_ONE_WDOG_CLR] = wdog_clear;
    aux_control_one_view[`AUX_CONTROL_ONE_TMR3_CLR] = timer_three_clear;
    aux_control_one_view[`AUX_CONTROL_ONE_CONV_START] = conv_start;
    aux_control_one_view[`AUX_CONTROL_ONE_LOWV_DIS] = lowv_reset_disable;
    aux_control_one_view[`AUX_CONTROL_ONE_T2_SEL] = timer_two_input_sel;
    aux_control_one_view[`AUX_CONTROL_ONE_T1_SEL] = timer_one_input_sel;
    aux_control_one_view[`AUX_CONTROL_ONE_PTR_SEL] = pointer_bank_sel;
    arith_view = 8'h00;
    arith_view[`ARITH_LONG_DIV] = long_divide_sel;
    arith_view[`ARITH_FPW_HI:`ARITH_FPW_LO] = flashprog_wdog_sel;
    arith_view[`ARITH_WIDE] = wide_arith_sel;
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else
    begin
      case (rsel)
        aux_control_pkg::SEL_AUX_CONTROL_ONE: rdata_o <= aux_control_one_view;
        aux_control_pkg::SEL_ARITH: rdata_o <= arith_view;
        aux_control_pkg::SEL_STATUS: rdata_o <= event_status;
        aux_control_pkg::SEL_MASK: rdata_o <= event_mask;
        aux_control_pkg::SEL_CFG: rdata_o <= flash_config_high;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ### logic/aux_control_params.svh
// Constants of the auxiliary control bit bank: offsets, fields, resets, times.
// Assumes a 100 MHz system clock and an 8-bit special function register port.
// Operation
// - Wide select picks 8-bit or 16-bit multiply/divide
// - Long divide picks 16/16 or 32/16 when wide
// - Flash-program watchdog: off, 1, 3.9, 7.8 ms
// - Watchdog clear strobe self-clears next cycle
// - Timer three clear strobe self-clears next cycle
// - Conversion start set by write, cleared at end
// - Low-voltage reset disable bit, resets to zero
// - Timer two counts pin or slow clock/16
// - Timer one counts pin or slow clock/16
// - Config bit 7 enables flash code protection
// - Config bit 6 enables external reset pin
// - Config bits 5..2 pick low-voltage trip level
`ifndef AUX_CONTROL_PARAMS_SVH
`define AUX_CONTROL_PARAMS_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define OFS_AUX_CONTROL_ONE 16'h00F8
`define OFS_ARITH_IAP_CONTROL 16'h00F9
`define OFS_EVENT_STATUS 16'h00FA
`define OFS_EVENT_MASK 16'h00FB
`define OFS_FLASH_CONFIG_HIGH 16'h3FFF

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define AUX_CONTROL_ONE_WDOG_CLR 7
`define AUX_CONTROL_ONE_TMR3_CLR 6
`define AUX_CONTROL_ONE_CONV_START 4
`define AUX_CONTROL_ONE_LOWV_DIS 3
`define AUX_CONTROL_ONE_T2_SEL 2
`define AUX_CONTROL_ONE_T1_SEL 1
`define AUX_CONTROL_ONE_PTR_SEL 0
`define ARITH_LONG_DIV 3
`define ARITH_FPW_HI 2
`define ARITH_FPW_LO 1
`define ARITH_WIDE 0
`define CFG_PROTECT 7
`define CFG_XRST_EN 6
`define CFG_LVR_HI 5
`define CFG_LVR_LO 2
`define EVT_FPW_TIMEOUT 0
`define EVT_CONV_DONE 1

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define RST_AUX_CONTROL_ONE 8'h00
`define RST_ARITH_IAP_CONTROL 8'h00
`define RST_FLASH_CONFIG_HIGH 8'h00
`define RST_EVENT 8'h00

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define FPW_TIME1_US 1000
`define FPW_TIME2_US 3900
`define FPW_TIME3_US 7800
`define SLOW_DIVIDE 16

`endif

// ### logic/aux_control_pkg.sv
// Types shared by the auxiliary control bit bank.
// Assumes the constants header is included by users of field positions.
package aux_control_pkg;

  typedef enum logic [1:0] {
    DIV_8_8 = 2'b00,
    DIV_16_16 = 2'b01,
    DIV_32_16 = 2'b10
  } div_mode_t;

  typedef struct packed {
    logic mul_wide;
    div_mode_t div_mode;
  } arith_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic code_protect;
    logic ext_reset_pin_en;
    logic [3:0] lowv_threshold_code;
  } flash_cfg_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_AUX_CONTROL_ONE = 3'b001,
    SEL_ARITH = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_MASK = 3'b100,
    SEL_CFG = 3'b101
  } reg_sel_t;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_HOLD = 2'b10
  } wd_state_t;

endpackage

// ### logic/flashprog_wdog.sv
// Flash-programming watchdog: counts while programming is active.
// Assumes active_i and clear_i come from logic on the same clock.
`timescale 1ns/1ns
module flashprog_wdog #(
  parameter int unsigned CYC1 = 100000,
  parameter int unsigned CYC2 = 390000,
  parameter int unsigned CYC3 = 780000,
  parameter int unsigned CW = 20
) (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [1:0] sel_i, // Timeout select code
  input wire logic active_i, // Flash programming under way
  input wire logic clear_i, // Restart the count
  output logic timeout_o, // One-cycle time-out pulse
  output logic running_o // Count in progress
);

  aux_control_pkg::wd_state_t state;
  logic [CW-1:0] count;
  logic [CW-1:0] limit;

  // --------------------------------------------------------------------------
  // Timeout length
  // --------------------------------------------------------------------------
  always_comb
  begin
    case (sel_i)
      2'b01: limit = CW'(CYC1 - 1);
      2'b10: limit = CW'(CYC2 - 1);
      2'b11: limit = CW'(CYC3 - 1);
      default: limit = '0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= aux_control_pkg::WD_IDLE;
      count <= '0;
      timeout_o <= 1'b0;
    end
    else
    begin
      timeout_o <= 1'b0;
      case (state)
        aux_control_pkg::WD_IDLE:
        begin
          count <= '0;
          if (active_i && sel_i != 2'b00)
            state <= aux_control_pkg::WD_RUN;
        end
        aux_control_pkg::WD_RUN:
        begin
          if (!active_i || sel_i == 2'b00)
            state <= aux_control_pkg::WD_IDLE;
          else if (clear_i)
            count <= '0;
          else if (count >= limit)
          begin
            timeout_o <= 1'b1;
            state <= aux_control_pkg::WD_HOLD;
          end
          else
            count <= count + CW'(1);
        end
        aux_control_pkg::WD_HOLD:
        begin
          // One flag per run; a new run needs programming to end or a clear
          count <= '0;
          if (!active_i || clear_i)
            state <= aux_control_pkg::WD_IDLE;
        end
        default: state <= aux_control_pkg::WD_IDLE;
      endcase
    end
  end

  assign running_o = (state == aux_control_pkg::WD_RUN);

endmodule

// ### bench/aux_control_chk.sv
// Concurrent checks on the ports of the auxiliary control bit bank.
// Assumes it is bound into aux_control_bits and shares its clock and reset.
`timescale 1ns/1ns
`include "aux_control_params.svh"
module aux_control_chk (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire aux_control_pkg::reg_req_t bus_req_i, // Register request
  input wire logic [7:0] rdata_o, // Read data
  input wire logic conv_done_i, // Conversion end pulse
  input wire logic flashprog_active_i, // Programming busy
  input wire logic [7:0] flash_cfg_word_i, // Config byte
  input wire logic timer_two_counter_mode_i, // Timer two counter mode
  input wire aux_control_pkg::arith_mode_t arith_mode_o, // Arith mode
  input wire logic wdog_clear_o, // Watchdog clear pulse
  input wire logic timer_three_clear_o, // Timer three clear pulse
  input wire logic conv_start_o, // Conversion request
  input wire logic lowv_reset_en_o, // Low-voltage reset on
  input wire logic timer_two_count_o, // Timer two count pulse
  input wire aux_control_pkg::flash_cfg_t flash_cfg_o, // Config fields
  input wire logic fpw_running_o // Flash watchdog counting
);
  logic aux_wr;
  logic arith_wr;
  assign aux_wr = bus_req_i.wr && bus_req_i.addr == `OFS_AUX_CONTROL_ONE;
  assign arith_wr = bus_req_i.wr && bus_req_i.addr == `OFS_ARITH_IAP_CONTROL;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // --------
  // Checks
  // --------
  sequence s_aux_bit(int b);
    aux_wr && bus_req_i.wdata[b];
  endsequence

  chk_wdog_pulse_set: assert property (s_aux_bit(7) |=> wdog_clear_o)
    else $error("watchdog clear pulse missing");
  chk_wdog_pulse_cause: assert property (wdog_clear_o |-> $past(aux_wr && bus_req_i.wdata[7]))
    else $error("watchdog clear pulse without write");
  chk_tmr3_pulse_set: assert property (s_aux_bit(6) |=> timer_three_clear_o)
    else $error("timer three clear pulse missing");
  chk_tmr3_pulse_cause: assert property (timer_three_clear_o |-> $past(aux_wr && bus_req_i.wdata[6]))
    else $error("timer three clear pulse without write");
  chk_conv_load: assert property (aux_wr |=> conv_start_o == $past(bus_req_i.wdata[4]))
    else $error("conversion start not loaded");
  chk_conv_end: assert property (conv_done_i && !aux_wr |=> !conv_start_o)
    else $error("conversion start kept after end");
  chk_lowv_polarity: assert property (aux_wr |=> lowv_reset_en_o != $past(bus_req_i.wdata[3]))
    else $error("low-voltage reset enable polarity");
  chk_arith_mode: assert property (arith_wr |=> arith_mode_o.mul_wide == $past(bus_req_i.wdata[0])
    && arith_mode_o.div_mode == ($past(bus_req_i.wdata[0]) ? ($past(bus_req_i.wdata[3]) ? 2'b10 : 2'b01)
    : 2'b00))
    else $error("arithmetic mode mismatch");
  chk_narrow_div: assert property (!arith_mode_o.mul_wide |-> arith_mode_o.div_mode == 2'b00)
    else $error("narrow mode with wide divide");
  chk_cfg_copy: assert property ($past(rst_n_i) |-> flash_cfg_o == $past(flash_cfg_word_i[7:2]))
    else $error("config fields not copied");
  chk_read_idle: assert property (!$past(bus_req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_timer_quiet: assert property (!timer_two_counter_mode_i [*4] |-> !timer_two_count_o)
    else $error("timer two counts outside counter mode");
  chk_fpw_idle: assert property (!flashprog_active_i ##1 !flashprog_active_i |-> !fpw_running_o)
    else $error("flash watchdog runs while idle");
endmodule

bind aux_control_bits aux_control_chk aux_control_chk_i (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .bus_req_i(bus_req_i),
  .rdata_o(rdata_o),
  .conv_done_i(conv_done_i),
  .flashprog_active_i(flashprog_active_i),
  .flash_cfg_word_i(flash_cfg_word_i),
  .timer_two_counter_mode_i(timer_two_counter_mode_i),
  .arith_mode_o(arith_mode_o),
  .wdog_clear_o(wdog_clear_o),
  .timer_three_clear_o(timer_three_clear_o),
  .conv_start_o(conv_start_o),
  .lowv_reset_en_o(lowv_reset_en_o),
  .timer_two_count_o(timer_two_count_o),
  .flash_cfg_o(flash_cfg_o),
  .fpw_running_o(fpw_running_o)
);

// ### bench/aux_control_bits_tb_top.sv
// Self-checking bench for the auxiliary control bit bank.
// Assumes the design and its bound checker are compiled before it.
`timescale 1ns/1ns
`include "aux_control_params.svh"
module aux_control_bits_tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  aux_control_pkg::reg_req_t req = '0;
  logic conv_done = 1'b0;
  logic fp_active = 1'b0;
  logic [7:0] cfg_word = 8'ha5;
  logic [1:0] mode = 2'b00; // [1] timer two, [0] timer one
  logic [1:0] pin = 2'b00;
  logic slow = 1'b0;
  logic [7:0] rdata;
  aux_control_pkg::arith_mode_t arith;
  aux_control_pkg::flash_cfg_t cfg;
  logic wdog_clr, t3_clr, conv_start, lowv_en, t2_cnt, t1_cnt, ptr, fpw_run, irq;
  int err_count = 0;
  int cmp_count = 0;
  int n1 = 0;
  int n2 = 0;

  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    if (t1_cnt === 1'b1) n1++;
    if (t2_cnt === 1'b1) n2++;
  end

  // Short watchdog counts keep the run brief
  aux_control_bits #(.FPW_CYC1(10), .FPW_CYC2(20), .FPW_CYC3(30)) aux_control_bits_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_req_i(req), .rdata_o(rdata),
    .conv_done_i(conv_done), .flashprog_active_i(fp_active), .flash_cfg_word_i(cfg_word),
    .timer_two_counter_mode_i(mode[1]), .timer_one_counter_mode_i(mode[0]),
    .timer_two_pin_i(pin[1]), .timer_one_pin_i(pin[0]), .slow_clock_i(slow),
    .arith_mode_o(arith), .wdog_clear_o(wdog_clr), .timer_three_clear_o(t3_clr),
    .conv_start_o(conv_start), .lowv_reset_en_o(lowv_en), .timer_two_count_o(t2_cnt),
    .timer_one_count_o(t1_cnt), .pointer_bank_sel_o(ptr), .flash_cfg_o(cfg),
    .fpw_running_o(fpw_run), .irq_o(irq));

  // --------
  // Tasks
  // --------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req <= '0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req <= '0;
    #1;
    chk($sformatf("read %h", a), e, rdata);
    @(posedge clock_i);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    chk("reset outputs", 8'h01, {5'h00, arith.div_mode, lowv_en});
    rd(`OFS_AUX_CONTROL_ONE, `RST_AUX_CONTROL_ONE);
    rd(`OFS_ARITH_IAP_CONTROL, `RST_ARITH_IAP_CONTROL);
    rd(`OFS_EVENT_STATUS, `RST_EVENT);
    rd(`OFS_EVENT_MASK, `RST_EVENT);
    wr(`OFS_FLASH_CONFIG_HIGH, 8'h5a);
    rd(`OFS_FLASH_CONFIG_HIGH, 8'ha5);
    wr(16'h00f0, 8'hff);
    rd(16'h00f0, 8'h00);
  endtask

  task automatic t_strobes();
    req <= '{addr: `OFS_AUX_CONTROL_ONE, wdata: 8'hc0, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req <= '0;
    #1;
    chk("clear strobes", 8'h03, {6'h00, wdog_clr, t3_clr});
    @(posedge clock_i);
    #1;
    chk("clear strobes off", 8'h00, {6'h00, wdog_clr, t3_clr});
    rd(`OFS_AUX_CONTROL_ONE, 8'h00);
  endtask

  task automatic t_conv();
    wr(`OFS_EVENT_MASK, 8'h02);
    wr(`OFS_AUX_CONTROL_ONE, 8'h10);
    rd(`OFS_AUX_CONTROL_ONE, 8'h10);
    conv_done <= 1'b1;
    @(posedge clock_i);
    conv_done <= 1'b0;
    @(posedge clock_i);
    #1;
    chk("conversion end", 8'h01, {6'h00, conv_start, irq});
    rd(`OFS_EVENT_STATUS, 8'h02);
    wr(`OFS_EVENT_STATUS, 8'h02);
    #1;
    chk("interrupt cleared", 8'h00, {7'h00, irq});
    wr(`OFS_AUX_CONTROL_ONE, 8'h10);
    wr(`OFS_AUX_CONTROL_ONE, 8'h00);
    #1;
    chk("software stop", 8'h00, {7'h00, conv_start});
  endtask

  task automatic t_arith();
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = {4'h0, i[1], i[1], i[0], i[0]};
      wr(`OFS_ARITH_IAP_CONTROL, d);
      #1;
      chk("arith mode", {5'h00, i[0], i[0] ? (i[1] ? 2'b10 : 2'b01) : 2'b00}, {5'h00, arith});
      rd(`OFS_ARITH_IAP_CONTROL, d);
    end
  endtask

  task automatic t_lowv();
    wr(`OFS_AUX_CONTROL_ONE, 8'h09);
    #1;
    chk("lowv off", 8'h01, {6'h00, lowv_en, ptr});
    wr(`OFS_AUX_CONTROL_ONE, 8'h00);
    #1;
    chk("lowv on", 8'h02, {6'h00, lowv_en, ptr});
  endtask

  task automatic t_cfg();
    logic [7:0] w;
    for (int i = 0; i < 16; i++)
    begin
      w = {i[0], i[1], i[3:0], 2'b01};
      cfg_word <= w;
      @(posedge clock_i);
      #1;
      chk("config fields", {2'b00, w[7:2]}, {2'b00, cfg});
      rd(`OFS_FLASH_CONFIG_HIGH, w);
    end
  endtask

  task automatic t_fpw();
    int n;
    int lim [4] = '{0, 10, 20, 30};
    wr(`OFS_EVENT_MASK, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFS_ARITH_IAP_CONTROL, 8'(c << 1));
      fp_active <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 100)
      begin
        @(posedge clock_i);
        n++;
      end
      chk("watchdog wait", 8'h01, {7'h00, (c == 0) ? n == 100 : n >= lim[c] && n <= lim[c] + 4});
      if (c != 0 && n == 100) results();
      fp_active <= 1'b0;
      @(posedge clock_i);
      wr(`OFS_EVENT_STATUS, 8'h01);
    end
  endtask

  task automatic t_tmr(input int one, input bit sel, input bit md, input int e);
    int base;
    base = one ? n1 : n2;
    mode <= md ? (one ? 2'b01 : 2'b10) : 2'b00;
    wr(`OFS_AUX_CONTROL_ONE, sel ? (one ? 8'h02 : 8'h04) : 8'h00);
    if (!sel)
    begin
      pin <= one ? 2'b01 : 2'b10;
      repeat (3) @(posedge clock_i);
      pin <= 2'b00;
    end
    else
      // 31 edges after 16 still give one pulse only for a divide of 16
      repeat (one ? 31 : 16)
      begin
        slow <= 1'b1;
        repeat (2) @(posedge clock_i);
        slow <= 1'b0;
        repeat (2) @(posedge clock_i);
      end
    repeat (8) @(posedge clock_i);
    #1;
    chk("timer pulses", 8'(e), 8'((one ? n1 : n2) - base));
  endtask

  // --------
  // Main
  // --------
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_strobes();
    t_conv();
    t_arith();
    t_lowv();
    t_cfg();
    t_fpw();
    t_tmr(0, 1'b0, 1'b1, 1);
    t_tmr(0, 1'b1, 1'b1, 1);
    t_tmr(1, 1'b0, 1'b1, 1);
    t_tmr(1, 1'b1, 1'b1, 1);
    t_tmr(0, 1'b0, 1'b0, 0);
    results();
  end
endmodule
